// ===== rtl/caf_consts.vh
// Constants for the CAN acceptance filter configuration block.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef CAF_CONSTS_VH
`define CAF_CONSTS_VH

// Byte offsets of the single registers
`define CAF_ADDR_BUFPTR4     8'h00
`define CAF_ADDR_MSKSEL1     8'h04
`define CAF_ADDR_MSKSEL2     8'h08
`define CAF_ADDR_STATUS      8'h0C
`define CAF_ADDR_HITCOUNT    8'h10
// Filter arrays: address[7:6] selects the array, address[5:2] the filter
`define CAF_REGION_SID       2'b01
`define CAF_REGION_EID       2'b10

// Reset values
`define CAF_RST_REG16        16'h0000
`define CAF_RST_ACK          1'b0

// Writable bits of the standard identifier register
`define CAF_SID_WMASK        16'hFFEB
`define CAF_ALL_WMASK        16'hFFFF

// Field positions in the standard identifier register
`define CAF_SID_MSB          15
`define CAF_SID_LSB          5
`define CAF_IDTYPE_BIT       3
`define CAF_EIDHI_MSB        1
`define CAF_EIDHI_LSB        0

// Mask source codes
`define CAF_MSK_NONE         2'b11
`define CAF_MSK_2            2'b10
`define CAF_MSK_1            2'b01
`define CAF_MSK_0            2'b00

// Buffer pointer code that steers hits to the receive FIFO
`define CAF_PTR_FIFO         4'hF

// Widths
`define CAF_SID_W            11
`define CAF_EID_W            18
`define CAF_FILTERS          16

`endif

// ===== rtl/caf_filter_match.v
// One acceptance filter: identifier and type comparison for a received frame.
// Assumes settings and frame fields are stable flops on the same clock.
`timescale 1ns/1ps
`include "caf_consts.vh"

module caf_filter_match (
  input  wire [15:0]               stdIdReg,
  input  wire [15:0]               extIdReg,
  input  wire [1:0]                maskSource,
  input  wire [`CAF_SID_W-1:0]     mask0Sid,
  input  wire [`CAF_EID_W-1:0]     mask0Eid,
  input  wire                      mask0IdTypeMatch,
  input  wire [`CAF_SID_W-1:0]     mask1Sid,
  input  wire [`CAF_EID_W-1:0]     mask1Eid,
  input  wire                      mask1IdTypeMatch,
  input  wire [`CAF_SID_W-1:0]     mask2Sid,
  input  wire [`CAF_EID_W-1:0]     mask2Eid,
  input  wire                      mask2IdTypeMatch,
  input  wire [`CAF_SID_W-1:0]     frameSid,
  input  wire [`CAF_EID_W-1:0]     frameEid,
  input  wire                      frameExt,
  output wire                      hit
);

  reg  [`CAF_SID_W-1:0] selSid;
  reg  [`CAF_EID_W-1:0] selEid;
  reg                   selMide;
  wire [`CAF_SID_W-1:0] stdIdMatch;
  wire [`CAF_EID_W-1:0] extIdMatch;
  wire                  sidOk;
  wire                  eidOk;
  wire                  typeOk;

  always @* begin
    case (maskSource)
      `CAF_MSK_0: begin
        selSid  = mask0Sid;
        selEid  = mask0Eid;
        selMide = mask0IdTypeMatch;
      end
      `CAF_MSK_1: begin
        selSid  = mask1Sid;
        selEid  = mask1Eid;
        selMide = mask1IdTypeMatch;
      end
      `CAF_MSK_2: begin
        selSid  = mask2Sid;
        selEid  = mask2Eid;
        selMide = mask2IdTypeMatch;
      end
      default: begin
        // No mask: every bit and the type take part
        selSid  = {`CAF_SID_W{1'b1}};
        selEid  = {`CAF_EID_W{1'b1}};
        selMide = 1'b1;
      end
    endcase
  end

  assign stdIdMatch = stdIdReg[`CAF_SID_MSB:`CAF_SID_LSB];
  assign extIdMatch = {stdIdReg[`CAF_EIDHI_MSB:`CAF_EIDHI_LSB], extIdReg};
  assign sidOk  = ((frameSid ^ stdIdMatch) & selSid) == {`CAF_SID_W{1'b0}};
  // Standard frames carry no extension, so those bits only count for extended frames
  assign eidOk  = ~frameExt | (((frameEid ^ extIdMatch) & selEid) == {`CAF_EID_W{1'b0}});
  assign typeOk = ~selMide | (frameExt == stdIdReg[`CAF_IDTYPE_BIT]);
  assign hit    = sidOk & eidOk & typeOk;

endmodule // caf_filter_match

// ===== rtl/caf_filter_top.v
// Acceptance filter settings for sixteen filters and frame matching.
// Assumes an Avalon-MM master on the same clock and frame fields from the
// protocol engine in the same clock domain; mask contents and buffer
// pointers of filters 0-11 come from elsewhere in the controller.
//
// Overview of operation
// - 18-bit extended match: top two bits in standard register, sixteen in own.
// - Each compared extended bit must equal the programmed one for a pass.
// - Type select set accepts only extended frames; clear accepts only standard.
// - Mask type-match bit zero makes the filter ignore its type select.
// - Mask source 11 none, 10 mask 2, 01 mask 1, 00 mask 0.
// - Filters 7..0 mask sources in two-bit fields, filter 7 at top, reset zero.
// - Pointers of filters 14, 13, 12 sit at bits 11-8, 7-4, 3-0.
// - Unimplemented standard identifier register bits always read zero.
// - Pointer 1111 steers hits to FIFO; 1110..0000 to buffers 14..0.
`timescale 1ns/1ps
`include "caf_consts.vh"

module caf_filter_top (
  input  wire                      clock,
  input  wire                      rst,
  input  wire [7:0]                avsAddress,
  input  wire [3:0]                avsByteEnable,
  input  wire                      avsRead,
  input  wire                      avsWrite,
  input  wire [31:0]               avsWriteData,
  output wire [31:0]               avsReadData,
  output wire                      avsWaitRequest,
  input  wire [`CAF_SID_W-1:0]     mask0Sid,
  input  wire [`CAF_EID_W-1:0]     mask0Eid,
  input  wire                      mask0IdTypeMatch,
  input  wire [`CAF_SID_W-1:0]     mask1Sid,
  input  wire [`CAF_EID_W-1:0]     mask1Eid,
  input  wire                      mask1IdTypeMatch,
  input  wire [`CAF_SID_W-1:0]     mask2Sid,
  input  wire [`CAF_EID_W-1:0]     mask2Eid,
  input  wire                      mask2IdTypeMatch,
  input  wire [47:0]               lowBufferPtrs,
  input  wire                      frameValid,
  input  wire [`CAF_SID_W-1:0]     frameSid,
  input  wire [`CAF_EID_W-1:0]     frameEid,
  input  wire                      frameExt,
  output wire                      matchValid,
  output wire                      matchHit,
  output wire [3:0]                matchFilter,
  output wire [3:0]                matchBufferPtr,
  output wire                      matchToFifo,
  output wire [15:0]               filterHits
);

  // Settings storage
  reg  [15:0] stdIdFf [0:`CAF_FILTERS-1];
  reg  [15:0] extIdFf [0:`CAF_FILTERS-1];
  reg  [15:0] maskSel1Ff;
  reg  [15:0] maskSel2Ff;
  reg  [15:0] bufPtr4Ff;
  reg  [15:0] hitCountFf;

  // Bus handshake
  reg         ackFf;
  reg  [31:0] readDataFf;
  reg  [15:0] readValue;
  wire        busReq;
  wire        wrEn;
  wire [1:0]  region;
  wire [3:0]  filterIdx;

  // Match results
  wire [15:0] hitVec;
  reg         matchValidFf;
  reg         matchHitFf;
  reg  [3:0]  matchFilterFf;
  reg  [3:0]  matchBufferPtrFf;
  reg         matchToFifoFf;
  reg  [15:0] filterHitsFf;
  reg         nxt_found;
  reg  [3:0]  nxt_filter;
  reg  [3:0]  nxt_ptr;
  reg  [15:0] nxt_hitCount;

  integer i;
  integer j;

  // Byte-lane merge of a 16-bit register; bits outside wmask stay zero
  function [15:0] mergeWrite;
    input [15:0] oldValue;
    input [31:0] data;
    input [3:0]  be;
    input [15:0] wmask;
    reg   [15:0] merged;
    begin
      merged[7:0]  = be[0] ? data[7:0]  : oldValue[7:0];
      merged[15:8] = be[1] ? data[15:8] : oldValue[15:8];
      mergeWrite   = merged & wmask;
    end
  endfunction

  // Two-bit mask source of filter n from the two selection registers
  function [1:0] maskSourceOf;
    input [15:0] sel1;
    input [15:0] sel2;
    input [3:0]  n;
    reg   [15:0] sel;
    begin
      sel          = n[3] ? sel2 : sel1;
      maskSourceOf = sel[{n[2:0], 1'b0} +: 2];
    end
  endfunction

  // Four-bit buffer pointer of filter n
  function [3:0] bufferPtrOf;
    input [47:0] low;
    input [15:0] high;
    input [3:0]  n;
    begin
      if (n >= 4'hC) begin
        bufferPtrOf = high[{n[1:0], 2'b00} +: 4];
      end else begin
        bufferPtrOf = low[{n, 2'b00} +: 4];
      end
    end
  endfunction

  // One wait state: the request is registered, then answered
  assign busReq         = avsRead | avsWrite;
  assign avsWaitRequest = busReq & ~ackFf;
  assign wrEn           = avsWrite & ackFf;
  assign region         = avsAddress[7:6];
  assign filterIdx      = avsAddress[5:2];
  assign avsReadData    = readDataFf;

  always @* begin
    readValue = 16'h0000;
    if (region == `CAF_REGION_SID) begin
      readValue = stdIdFf[filterIdx] & `CAF_SID_WMASK;
    end else if (region == `CAF_REGION_EID) begin
      readValue = extIdFf[filterIdx];
    end else begin
      case (avsAddress)
        `CAF_ADDR_BUFPTR4:  readValue = bufPtr4Ff;
        `CAF_ADDR_MSKSEL1:  readValue = maskSel1Ff;
        `CAF_ADDR_MSKSEL2:  readValue = maskSel2Ff;
        `CAF_ADDR_STATUS:   readValue = {6'h00, matchHitFf, matchToFifoFf,
                                         matchFilterFf, matchBufferPtrFf};
        `CAF_ADDR_HITCOUNT: readValue = hitCountFf;
        default:            readValue = 16'h0000;
      endcase
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      ackFf      <= `CAF_RST_ACK;
      readDataFf <= 32'h0000_0000;
    end else begin
      ackFf <= busReq & ~ackFf;
      if (avsRead & ~ackFf) begin
        readDataFf <= {16'h0000, readValue};
      end
    end
  end

  // Settings registers; unmapped writes are dropped
  always @(posedge clock) begin
    if (rst) begin
      maskSel1Ff <= `CAF_RST_REG16;
      maskSel2Ff <= `CAF_RST_REG16;
      bufPtr4Ff  <= `CAF_RST_REG16;
      for (i = 0; i < `CAF_FILTERS; i = i + 1) begin
        stdIdFf[i] <= `CAF_RST_REG16;
        extIdFf[i] <= `CAF_RST_REG16;
      end
    end else if (wrEn) begin
      if (region == `CAF_REGION_SID) begin
        stdIdFf[filterIdx] <= mergeWrite(stdIdFf[filterIdx], avsWriteData,
                                         avsByteEnable, `CAF_SID_WMASK);
      end else if (region == `CAF_REGION_EID) begin
        extIdFf[filterIdx] <= mergeWrite(extIdFf[filterIdx], avsWriteData,
                                         avsByteEnable, `CAF_ALL_WMASK);
      end else begin
        case (avsAddress)
          `CAF_ADDR_BUFPTR4: begin
            bufPtr4Ff <= mergeWrite(bufPtr4Ff, avsWriteData, avsByteEnable,
                                    `CAF_ALL_WMASK);
          end
          `CAF_ADDR_MSKSEL1: begin
            maskSel1Ff <= mergeWrite(maskSel1Ff, avsWriteData, avsByteEnable,
                                     `CAF_ALL_WMASK);
          end
          `CAF_ADDR_MSKSEL2: begin
            maskSel2Ff <= mergeWrite(maskSel2Ff, avsWriteData, avsByteEnable,
                                     `CAF_ALL_WMASK);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Sixteen comparators work in parallel on the same frame
  genvar g;
  generate
    for (g = 0; g < `CAF_FILTERS; g = g + 1) begin : gFilter
      // A genvar cannot be part-selected, so the index is narrowed here
      localparam [3:0] FILTER_IDX = g;
      caf_filter_match uMatch (
        .stdIdReg         (stdIdFf[g]),
        .extIdReg         (extIdFf[g]),
        .maskSource       (maskSourceOf(maskSel1Ff, maskSel2Ff, FILTER_IDX)),
        .mask0Sid         (mask0Sid),
        .mask0Eid         (mask0Eid),
        .mask0IdTypeMatch (mask0IdTypeMatch),
        .mask1Sid         (mask1Sid),
        .mask1Eid         (mask1Eid),
        .mask1IdTypeMatch (mask1IdTypeMatch),
        .mask2Sid         (mask2Sid),
        .mask2Eid         (mask2Eid),
        .mask2IdTypeMatch (mask2IdTypeMatch),
        .frameSid         (frameSid),
        .frameEid         (frameEid),
        .frameExt         (frameExt),
        .hit              (hitVec[g])
      );
    end
  endgenerate

  // Lowest-numbered hitting filter wins when several accept the frame
  always @* begin
    nxt_found  = 1'b0;
    nxt_filter = 4'h0;
    for (j = `CAF_FILTERS - 1; j >= 0; j = j - 1) begin
      if (hitVec[j]) begin
        nxt_found  = 1'b1;
        nxt_filter = j[3:0];
      end
    end
    nxt_ptr = bufferPtrOf(lowBufferPtrs, bufPtr4Ff, nxt_filter);
  end

  // Saturating count of accepted frames; a write restarts it
  always @* begin
    nxt_hitCount = hitCountFf;
    if (wrEn && avsAddress == `CAF_ADDR_HITCOUNT) begin
      nxt_hitCount = 16'h0000;
    end
    if (frameValid && nxt_found && nxt_hitCount != 16'hFFFF) begin
      nxt_hitCount = nxt_hitCount + 16'h0001;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      matchValidFf     <= 1'b0;
      matchHitFf       <= 1'b0;
      matchFilterFf    <= 4'h0;
      matchBufferPtrFf <= 4'h0;
      matchToFifoFf    <= 1'b0;
      filterHitsFf     <= 16'h0000;
      hitCountFf       <= 16'h0000;
    end else begin
      matchValidFf <= frameValid;
      hitCountFf   <= nxt_hitCount;
      if (frameValid) begin
        matchHitFf       <= nxt_found;
        matchFilterFf    <= nxt_filter;
        matchBufferPtrFf <= nxt_found ? nxt_ptr : 4'h0;
        matchToFifoFf    <= nxt_found & (nxt_ptr == `CAF_PTR_FIFO);
        filterHitsFf     <= hitVec;
      end
    end
  end

  assign matchValid     = matchValidFf;
  assign matchHit       = matchHitFf;
  assign matchFilter    = matchFilterFf;
  assign matchBufferPtr = matchBufferPtrFf;
  assign matchToFifo    = matchToFifoFf;
  assign filterHits     = filterHitsFf;

endmodule // caf_filter_top

// ===== verification/caf_filter_assertions.sv
// Checker for the acceptance filter top: bus handshake and match outputs.
// Assumes a bind onto caf_filter_top; sees only its ports.
`timescale 1ns/1ps

module caf_filter_assertions (
  input wire        clock,
  input wire        rst,
  input wire [7:0]  avsAddress,
  input wire        avsRead,
  input wire        avsWrite,
  input wire [31:0] avsReadData,
  input wire        avsWaitRequest,
  input wire [47:0] lowBufferPtrs,
  input wire        frameValid,
  input wire        matchValid,
  input wire        matchHit,
  input wire [3:0]  matchFilter,
  input wire [3:0]  matchBufferPtr,
  input wire        matchToFifo,
  input wire [15:0] filterHits
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence seqWaitCycle;
    (avsRead || avsWrite) && avsWaitRequest;
  endsequence
  sequence seqSidReadDone;
    avsRead && !avsWaitRequest && avsAddress[7:6] == 2'h1;
  endsequence

  chk_first_wait: assert property ($rose(avsRead || avsWrite) |-> avsWaitRequest)
    else $error("request without wait state");
  chk_one_wait: assert property (seqWaitCycle |=> !avsWaitRequest)
    else $error("wait state longer than one cycle");
  chk_sid_unused: assert property (seqSidReadDone |-> avsReadData[4] == 1'b0 && avsReadData[2] == 1'b0)
    else $error("unused id bits read as one");
  chk_upper_zero: assert property (avsReadData[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_match_latency: assert property (frameValid |=> matchValid)
    else $error("match result late");
  chk_match_pulse: assert property (!frameValid |=> !matchValid)
    else $error("match result without frame");
  chk_hit_vector: assert property (matchValid |-> matchHit == (filterHits != 16'h0000))
    else $error("hit flag disagrees with vector");
  chk_lowest_wins: assert property (matchValid && matchHit |-> filterHits[matchFilter] &&
    (filterHits & ((16'h0001 << matchFilter) - 16'h0001)) == 16'h0000)
    else $error("winning filter not lowest");
  chk_low_ptr: assert property (matchValid && matchHit && matchFilter < 4'hC |->
    matchBufferPtr == 4'($past(lowBufferPtrs) >> {matchFilter, 2'h0}))
    else $error("wrong pointer for low filter");
  chk_fifo_code: assert property (matchValid |-> matchToFifo == (matchHit && matchBufferPtr == 4'hF))
    else $error("fifo steering wrong");
  chk_result_hold: assert property (!frameValid |=> $stable(filterHits) && $stable(matchBufferPtr))
    else $error("result changed without frame");
endmodule // caf_filter_assertions

// ===== verification/caf_testbench.sv
// Self-checking bench for the acceptance filter top: registers and matching.
// Assumes caf_filter_top and caf_consts.vh on the include path.
`timescale 1ns/1ps
`include "caf_consts.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end

module testbench;
  typedef struct packed {
    logic [15:0] sid;
    logic [15:0] eid;
    logic [1:0]  msk;
    logic [10:0] fSid;
    logic [17:0] fEid;
    logic        fExt;
    logic        hit;
  } caf_row_t;
  logic        clock = 0, rst = 1, avsRead = 0, avsWrite = 0, frameValid = 0, frameExt = 0;
  logic [7:0]  avsAddress = 8'h00;
  logic [31:0] avsWriteData = 32'h0000_0000;
  logic [10:0] frameSid = 11'h000, m0Sid = 11'h7FF, m1Sid = 11'h7FE, m2Sid = 11'h000;
  logic [17:0] frameEid = 18'h0_0000, m0Eid = 18'h3_FFFF, m1Eid = 18'h0_0000, m2Eid = 18'h0_0000;
  logic        m0Type = 1, m1Type = 0, m2Type = 1;
  logic [3:0]  byteEn = 4'hF;
  logic [47:0] lowPtrs = 48'h0000_9000_0005;
  logic [15:0] rd;
  wire  [31:0] avsReadData;
  wire         avsWaitRequest, matchValid, matchHit, matchToFifo;
  wire  [3:0]  matchFilter, matchBufferPtr;
  wire  [15:0] filterHits;
  int          n_errors = 0, compares = 0;
  caf_row_t    rows [10] = '{
    '{16'h2460, 16'h0000, 2'h0, 11'h123, 18'h0_0000, 1'b0, 1'b1},
    '{16'h2460, 16'h0000, 2'h0, 11'h122, 18'h0_0000, 1'b0, 1'b0},
    '{16'h246A, 16'hA5A5, 2'h0, 11'h123, 18'h2_A5A5, 1'b1, 1'b1},
    '{16'h246A, 16'hA5A5, 2'h0, 11'h123, 18'h2_A5A4, 1'b1, 1'b0},
    '{16'h246A, 16'hA5A5, 2'h0, 11'h123, 18'h0_0000, 1'b0, 1'b0},
    '{16'h246A, 16'hA5A5, 2'h1, 11'h122, 18'h0_0000, 1'b0, 1'b1},
    '{16'h2460, 16'h0000, 2'h3, 11'h123, 18'h3_FFFF, 1'b0, 1'b1},
    '{16'h2460, 16'h0000, 2'h3, 11'h122, 18'h0_0000, 1'b0, 1'b0},
    '{16'h2460, 16'h0000, 2'h2, 11'h7FF, 18'h0_0000, 1'b0, 1'b1},
    '{16'h2460, 16'h0000, 2'h2, 11'h7FF, 18'h0_0000, 1'b1, 1'b0}};

  caf_filter_top uut (.clock(clock), .rst(rst), .avsAddress(avsAddress),
    .avsByteEnable(byteEn), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .mask0Sid(m0Sid), .mask0Eid(m0Eid), .mask0IdTypeMatch(m0Type),
    .mask1Sid(m1Sid), .mask1Eid(m1Eid), .mask1IdTypeMatch(m1Type),
    .mask2Sid(m2Sid), .mask2Eid(m2Eid), .mask2IdTypeMatch(m2Type),
    .lowBufferPtrs(lowPtrs), .frameValid(frameValid), .frameSid(frameSid),
    .frameEid(frameEid), .frameExt(frameExt), .matchValid(matchValid), .matchHit(matchHit),
    .matchFilter(matchFilter), .matchBufferPtr(matchBufferPtr), .matchToFifo(matchToFifo),
    .filterHits(filterHits));

  initial forever #4 clock = ~clock;

  // Holds the request until the edge that sees no wait, then releases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd);
    avsAddress <= a;
    avsWriteData <= {16'h0000, wd};
    avsWrite <= wr;
    avsRead <= ~wr;
    // No cycle limit here: only the watchdog ends a hung request
    do begin
      @(posedge clock);
    end while (avsWaitRequest !== 1'b0);
    rd = avsReadData[15:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK(rd, e)
  endtask

  task automatic frame(input logic [10:0] s, input logic [17:0] e, input logic x,
                       input logic [3:0] f, input logic [3:0] p, input logic [15:0] h);
    frameSid <= s;
    frameEid <= e;
    frameExt <= x;
    frameValid <= 1'b1;
    @(posedge clock);
    frameValid <= 1'b0;
    #1;
    `CHK(matchValid, 1'b1)
    `CHK({matchHit, matchFilter, matchBufferPtr}, {h != 16'h0000, f, p})
    `CHK(matchToFifo, p == 4'hF)
    `CHK(filterHits, h)
    @(posedge clock);
  endtask

  task finish_test();
    $display("TB: errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdChk(`CAF_ADDR_MSKSEL1, 16'h0000);
    rdChk(`CAF_ADDR_BUFPTR4, 16'h0000);
    foreach (rows[k]) begin
      bus(1'b1, 8'h40, rows[k].sid);
      bus(1'b1, 8'h80, rows[k].eid);
      bus(1'b1, `CAF_ADDR_MSKSEL1, {14'h0000, rows[k].msk});
      frame(rows[k].fSid, rows[k].fEid, rows[k].fExt, 4'h0, rows[k].hit ? 4'h5 : 4'h0,
            {15'h0000, rows[k].hit});
    end
    bus(1'b1, 8'h40, 16'hFFFF);
    rdChk(8'h40, 16'hFFEB);
    bus(1'b1, 8'h80, 16'h5A5A);
    rdChk(8'h80, 16'h5A5A);
    byteEn <= 4'h1;
    bus(1'b1, 8'h80, 16'hFFFF);
    byteEn <= 4'hF;
    rdChk(8'h80, 16'h5AFF);
    // Filter 7 through mask 1 only hits if its field sits at the top
    bus(1'b1, `CAF_ADDR_MSKSEL1, 16'h4000);
    rdChk(`CAF_ADDR_MSKSEL1, 16'h4000);
    bus(1'b1, 8'h5C, 16'h2AA0);
    frame(11'h154, 18'h0_0000, 1'b0, 4'h7, 4'h9, 16'h0080);
    bus(1'b1, `CAF_ADDR_BUFPTR4, 16'hFE21);
    rdChk(`CAF_ADDR_BUFPTR4, 16'hFE21);
    bus(1'b1, `CAF_ADDR_MSKSEL2, 16'hC000);
    bus(1'b1, 8'h7C, 16'h7860);
    frame(11'h3C3, 18'h0_0000, 1'b0, 4'hF, 4'hF, 16'h8000);
    bus(1'b1, 8'h78, 16'h7860);
    frame(11'h3C3, 18'h0_0000, 1'b0, 4'hE, 4'hE, 16'hC000);
    bus(1'b1, 8'h70, 16'h7860);
    frame(11'h3C3, 18'h0_0000, 1'b0, 4'hC, 4'h1, 16'hD000);
    rdChk(`CAF_ADDR_STATUS, 16'h02C1);
    rdChk(`CAF_ADDR_HITCOUNT, 16'h0009);
    bus(1'b1, `CAF_ADDR_HITCOUNT, 16'h0000);
    rdChk(`CAF_ADDR_HITCOUNT, 16'h0000);
    rdChk(`CAF_ADDR_MSKSEL2, 16'hC000);
    rdChk(8'h3C, 16'h0000);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdChk(`CAF_ADDR_MSKSEL1, 16'h0000);
    finish_test();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #200_000;
    n_errors++;
    finish_test();
  end
endmodule // testbench

bind caf_filter_top caf_filter_assertions chk (.clock(clock), .rst(rst),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .lowBufferPtrs(lowBufferPtrs),
  .frameValid(frameValid), .matchValid(matchValid), .matchHit(matchHit),
  .matchFilter(matchFilter), .matchBufferPtr(matchBufferPtr), .matchToFifo(matchToFifo),
  .filterHits(filterHits));
